// ---- irq_logic_pkg.sv ----
// constants, register map and carrier types for the interrupt logic
package irq_logic_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [9:0] IDX_IRQ_CONTROL = 10'h00b;
    localparam logic [9:0] IDX_PERIPH_FLAGS = 10'h00c;
    localparam logic [9:0] IDX_PERIPH_ENABLES = 10'h08c;
    localparam logic [9:0] IDX_OPTION = 10'h081;
    localparam logic [9:0] IDX_PIN_CHANGE_ENABLE = 10'h096;
    localparam logic [9:0] IDX_STATUS = 10'h0a0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPH = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [5:0] RST_PIN_CHANGE = 6'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTL_GEN = 7;
    localparam int CTL_PGATE = 6;
    localparam int CTL_TZIE = 5;
    localparam int CTL_EXTIE = 4;
    localparam int CTL_PCIE = 3;
    localparam int CTL_TZIF = 2;
    localparam int CTL_EXTIF = 1;
    localparam int CTL_PCIF = 0;
    localparam int OPT_EDGE = 6;
    localparam int PF_TMR1 = 0;
    localparam int PF_OSCF = 2;
    localparam int PF_CMP1 = 3;
    localparam int PF_CMP2 = 4;
    localparam int PF_CR = 5;
    localparam int PF_LV = 6;
    localparam int PF_EEWR = 7;
    // bit 1 of the peripheral pair is not implemented
    localparam logic [7:0] PERIPH_IMPL_MASK = 8'hfd;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    // instruction cycles from the first q1 sample to vector entry
    localparam logic [1:0] ENTRY_STAGES = 2'h2;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam int PORT_PINS = 6;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic timer_zero_rollover;
        logic timer_one_overflow;
        logic osc_fail;
        logic comparator_one;
        logic comparator_two;
        logic cr_event;
        logic low_voltage;
        logic eeprom_write_done;
    } event_in_t;

    typedef struct packed {
        logic en_clear;         // an instruction clearing the enable ran
        logic return_from_irq;  // return-from-interrupt executed
        logic sleeping;         // core is in sleep
        logic port_read;        // core reads the port
    } core_in_t;

    typedef struct packed {
        logic vector_load;      // load pc with the vector (pulse)
        logic push_return;      // push return pc (pulse)
        logic [12:0] vector_addr;
        logic wake_request;
        logic irq_pending;
    } core_out_t;

endpackage : irq_logic_pkg

// ---- mcu_interrupt_logic.sv ----
// interrupt logic: flags, masks, global enable, vectoring and wake
`timescale 1ns/1ps


module mcu_interrupt_logic
    import irq_logic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin,
    input wire logic [irq_logic_pkg::PORT_PINS-1:0] port_pins,
    input irq_logic_pkg::event_in_t events,
    input irq_logic_pkg::core_in_t core_in,
    output irq_logic_pkg::core_out_t core_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] irq_control_reg;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] peripheral_irq_enables;
    logic [7:0] option_reg;
    logic [PORT_PINS-1:0] pin_change_enable_reg;
    logic [PORT_PINS-1:0] port_latch;
    logic [1:0] q_phase;
    logic [1:0] entry_stage;
    logic ext_pin_prev;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic [9:0] reg_index;
    logic access;
    logic wr_done;
    logic hit;
    logic [7:0] wbyte;

    assign reg_index = paddr[11:2];
    assign access = psel & penable;
    // a write lands only at the completing edge of the access phase
    assign wr_done = access & pready & pwrite;
    assign wbyte = pwdata[7:0];

    always_comb begin
        unique case (reg_index)
            IDX_IRQ_CONTROL, IDX_PERIPH_FLAGS, IDX_PERIPH_ENABLES,
            IDX_OPTION, IDX_PIN_CHANGE_ENABLE, IDX_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // event detection
    // ****************************************************************
    logic ext_edge;
    logic port_change;
    logic [7:0] periph_set;
    logic [2:0] ctl_set;
    logic glb_en;

    // global enable; gates entry only,
    // not flags, pending or wake
    assign glb_en = irq_control_reg[CTL_GEN];

    // edge polarity picked by the option bit
    assign ext_edge = option_reg[OPT_EDGE] ? (ext_irq_pin & ~ext_pin_prev)
                                           : (~ext_irq_pin & ext_pin_prev);

    // a mismatch against the read latch on an enabled pin; a read at q2
    // refreshes the latch, so a change in that very cycle can vanish
    assign port_change = |((port_pins ^ port_latch) & pin_change_enable_reg);

    // hardware set terms for the control register flags
    assign ctl_set[CTL_PCIF] = port_change;
    assign ctl_set[CTL_EXTIF] = ext_edge;
    // one pclk of rollover is enough:
    // the flag holds until cleared
    assign ctl_set[CTL_TZIF] = events.timer_zero_rollover;

    // peripheral set terms, one per implemented bit
    // set wins over a same-cycle clear,
    // so no event is lost to software;
    // unimplemented bit 1 is never set
    always_comb begin
        periph_set = 8'h00;
        periph_set[PF_TMR1] = events.timer_one_overflow;
        periph_set[PF_OSCF] = events.osc_fail;
        periph_set[PF_CMP1] = events.comparator_one;
        periph_set[PF_CMP2] = events.comparator_two;
        periph_set[PF_CR] = events.cr_event;
        periph_set[PF_LV] = events.low_voltage;
        periph_set[PF_EEWR] = events.eeprom_write_done;
    end

    // ****************************************************************
    // request combine
    // ****************************************************************
    logic ctl_req;
    logic periph_req;
    logic any_req;

    // each control flag masked by its own enable
    // a flag with its enable clear stays
    // visible to polling but never asks
    assign ctl_req =
        (irq_control_reg[CTL_EXTIF] & irq_control_reg[CTL_EXTIE]) |
        (irq_control_reg[CTL_TZIF] & irq_control_reg[CTL_TZIE]) |
        (irq_control_reg[CTL_PCIF] & irq_control_reg[CTL_PCIE]);

    // peripheral requests pass the peripheral gate first
    // so one bit can silence all seven
    // peripheral sources while their
    // flags and enables are kept
    assign periph_req = irq_control_reg[CTL_PGATE] &
        (|(peripheral_irq_flags & peripheral_irq_enables));

    // pending ignores the global enable,
    // as wake does
    assign any_req = ctl_req | periph_req;

    // ****************************************************************
    // instruction cycle phases
    // ****************************************************************
    // four pclk per instruction cycle, q1 first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_phase <= PHASE_Q1;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // ****************************************************************
    // pin history and port read latch
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pin_prev <= 1'b0;
            port_latch <= '0;
        end else begin
            ext_pin_prev <= ext_irq_pin;
            // the core's read snapshots the port at q2
            // a change landing on that edge is
            // absorbed into the latch: a known
            // blind spot, accepted
            if (core_in.port_read && q_phase == PHASE_Q2) begin
                port_latch <= port_pins;
            end
        end
    end

    // ****************************************************************
    // entry pipeline
    // ****************************************************************
    logic entry_fire;
    logic en_dropping;

    // an instruction or a bus write dropping
    // the enable aborts the entry
    assign en_dropping = core_in.en_clear |
        (wr_done && reg_index == IDX_IRQ_CONTROL && !wbyte[CTL_GEN]);

    // a sleeping core is woken first; it
    // takes no vector until sleep ends
    assign entry_fire = (q_phase == PHASE_Q1) &&
        (entry_stage == ENTRY_STAGES) && glb_en && !en_dropping &&
        !core_in.sleeping;

    // requests are looked at only on q1, so an event caught in q4..q1 is
    // seen at the next q1 and vectored two cycles later
    // stage 0 idle, 1 and 2 count whole
    // instruction cycles, so a one or two
    // cycle instruction gives the same
    // latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_stage <= 2'h0;
        end else if (!glb_en || en_dropping || core_in.sleeping) begin
            // ignored, but flags stay so it is taken later
            // restarting costs latency, never
            // a request: the flag still stands
            entry_stage <= 2'h0;
        end else if (q_phase == PHASE_Q1) begin
            if (entry_stage == ENTRY_STAGES) begin
                entry_stage <= 2'h0;
            end else if (entry_stage != 2'h0) begin
                entry_stage <= entry_stage + 2'h1;
            end else if (any_req && !core_in.sleeping) begin
                entry_stage <= 2'h1;
            end
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    // flags take set over clear so no event is lost under a software
    // clear; hardware never clears them itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_control_reg <= RST_IRQ_CONTROL;
        end else begin
            // a write owns bit 7 outright; the
            // flags still take set over clear
            if (wr_done && reg_index == IDX_IRQ_CONTROL) begin
                irq_control_reg[7:3] <= wbyte[7:3];
                irq_control_reg[2:0] <= wbyte[2:0] | ctl_set;
            end else begin
                irq_control_reg[2:0] <= irq_control_reg[2:0] | ctl_set;
                // an instruction clear outranks entry
                // and return in the same cycle
                if (core_in.en_clear) begin
                    irq_control_reg[CTL_GEN] <= 1'b0;
                end else if (entry_fire) begin
                    // entry drops the enable so the
                    // routine is not re-entered
                    irq_control_reg[CTL_GEN] <= 1'b0;
                end else if (core_in.return_from_irq) begin
                    // flags left set will vector
                    // again once this lands
                    irq_control_reg[CTL_GEN] <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // peripheral flags and enables
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_flags <= RST_PERIPH;
        end else if (wr_done && reg_index == IDX_PERIPH_FLAGS) begin
            peripheral_irq_flags <=
                (wbyte | periph_set) & PERIPH_IMPL_MASK;
        end else begin
            peripheral_irq_flags <= peripheral_irq_flags | periph_set;
        end
    end

    // enables are pure storage; bit 1
    // is tied low like its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_enables <= RST_PERIPH;
        end else if (wr_done && reg_index == IDX_PERIPH_ENABLES) begin
            peripheral_irq_enables <= wbyte & PERIPH_IMPL_MASK;
        end
    end

    // ****************************************************************
    // option and pin change enables
    // ****************************************************************
    // only the edge select bit is used here; the rest is plain storage
    // the option byte keeps all eight bits
    // so software reads back what it wrote
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_reg <= RST_OPTION;
            pin_change_enable_reg <= RST_PIN_CHANGE;
        end else if (wr_done) begin
            if (reg_index == IDX_OPTION) begin
                option_reg <= wbyte;
            end
            if (reg_index == IDX_PIN_CHANGE_ENABLE) begin
                pin_change_enable_reg <= wbyte[PORT_PINS-1:0];
            end
        end
    end

    // ****************************************************************
    // core outputs
    // ****************************************************************
    // only the return pc is pushed; no other context is saved
    // working and status copies are the
    // service routine's job; all outputs
    // are registered, one cycle behind
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_out <= '0;
        end else begin
            core_out.vector_load <= entry_fire;
            core_out.push_return <= entry_fire;
            core_out.vector_addr <= IRQ_VECTOR;
            core_out.irq_pending <= any_req;
            // wake ignores the global enable; the core then vectors only
            // if the enable is set
            core_out.wake_request <= core_in.sleeping & any_req;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    logic [7:0] rbyte;

    // bytes sit in prdata[7:0]; unused
    // and write cycles read as zero; the
    // status word is a debug aid only
    always_comb begin
        rbyte = 8'h00;
        unique case (reg_index)
            IDX_IRQ_CONTROL: rbyte = irq_control_reg;
            IDX_PERIPH_FLAGS: rbyte = peripheral_irq_flags;
            IDX_PERIPH_ENABLES: rbyte = peripheral_irq_enables;
            IDX_OPTION: rbyte = option_reg;
            IDX_PIN_CHANGE_ENABLE: rbyte = {2'h0, pin_change_enable_reg};
            IDX_STATUS: rbyte = {2'h0, core_out.wake_request,
                                 core_out.irq_pending, entry_stage, q_phase};
            default: rbyte = 8'h00;
        endcase
    end

    // ****************************************************************
    // apb answer
    // ****************************************************************
    // one wait state keeps prdata, pready and pslverr on flip-flops
    // cost: every access takes three
    // cycles; gain: no comb path from
    // psel to the bus outputs; an
    // unmapped index answers with an
    // error and changes nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
            pslverr <= ~hit;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

endmodule : mcu_interrupt_logic

// ---- irq_logic_props.sv ----
// port-level assertion checker for the interrupt logic
`timescale 1ns/1ps
module irq_logic_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_irq_pin,
    input wire logic [irq_logic_pkg::PORT_PINS-1:0] port_pins,
    input irq_logic_pkg::event_in_t events,
    input irq_logic_pkg::core_in_t core_in,
    input irq_logic_pkg::core_out_t core_out
);
    import irq_logic_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // core side
    // ****************************************************************
    a_entry_pulse_pair: assert property (
        core_out.vector_load == core_out.push_return)
        else $error("vector load and push differ");
    a_vector_fixed: assert property ($past(presetn) |->
        core_out.vector_addr == IRQ_VECTOR)
        else $error("vector address wrong");
    a_entry_single: assert property (
        core_out.vector_load |=> !core_out.vector_load)
        else $error("entry repeated");
    a_entry_needs_req: assert property (
        $rose(core_out.vector_load) |-> $past(core_out.irq_pending))
        else $error("entry without request");
    a_sleep_no_entry: assert property (
        core_in.sleeping [*2] |=> !core_out.vector_load)
        else $error("entry while sleeping");
    a_wake_cause: assert property (
        core_out.wake_request |-> $past(core_in.sleeping))
        else $error("wake without sleep");
    a_wake_on_req: assert property (
        (core_in.sleeping && core_out.irq_pending) [*2]
        |-> core_out.wake_request)
        else $error("no wake on request");
    // ****************************************************************
    // register bus
    // ****************************************************************
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_unimpl_bit: assert property (
        pready && !pwrite && (paddr[11:2] == IDX_PERIPH_FLAGS ||
        paddr[11:2] == IDX_PERIPH_ENABLES) |-> prdata[1] == 1'b0)
        else $error("bit one not zero");
    c_entry: cover property (core_out.vector_load);
    c_wake: cover property (core_out.wake_request);
    c_err: cover property (pslverr);
endmodule : irq_logic_props

bind mcu_interrupt_logic irq_logic_props props_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .port_pins(port_pins), .events(events), .core_in(core_in),
    .core_out(core_out)
);

// ---- irq_core_model.sv ----
// behavioural model of the processor core facing the interrupt logic
`timescale 1ns/1ps
module irq_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input irq_logic_pkg::core_out_t core_out,
    input wire logic ret_cmd,
    input wire logic clr_cmd,
    input wire logic sleep_cmd,
    output irq_logic_pkg::core_in_t core_in,
    output int entries
);
    import irq_logic_pkg::*;
    // instruction effects; port reads unused, so the port latch stays put
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_in <= '0;
            entries <= 0;
        end else begin
            core_in.return_from_irq <= ret_cmd;
            core_in.en_clear <= clr_cmd;
            core_in.port_read <= 1'b0;
            // a wake request ends sleep, enable or not
            core_in.sleeping <= core_in.sleeping ?
                !core_out.wake_request : sleep_cmd;
            entries <= entries + int'(core_out.vector_load);
        end
    end
endmodule : irq_core_model

// ---- mcu_interrupt_logic_tb.sv ----
// self-checking testbench for the interrupt logic
`timescale 1ns/1ps
module mcu_interrupt_logic_tb;
    import irq_logic_pkg::*;
    typedef struct {logic rd; logic [7:0] d; logic err;} note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_irq_pin = 1'b0;
    logic [PORT_PINS-1:0] port_pins = '0;
    event_in_t events = '0;
    core_in_t core_in;
    core_out_t core_out;
    logic ret_cmd = 1'b0;
    logic clr_cmd = 1'b0;
    logic sleep_cmd = 1'b0;
    int entries;
    int n_errors = 0;
    int total_checks = 0;
    int lat;
    note_t notes[$];
    note_t nt;
    logic [7:0] ev;

    mcu_interrupt_logic dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
        .port_pins(port_pins), .events(events), .core_in(core_in),
        .core_out(core_out));
    irq_core_model core_u (.pclk(pclk), .presetn(presetn),
        .core_out(core_out), .ret_cmd(ret_cmd), .clr_cmd(clr_cmd),
        .sleep_cmd(sleep_cmd), .core_in(core_in), .entries(entries));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] s, input logic [31:0] w,
                         input string what);
        total_checks++;
        if (s !== w) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, w, s);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    // one apb transfer; the answer is judged by the watcher below
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [7:0] d, input logic [7:0] w,
                       input logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        notes.push_back('{!wr, w, err});
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            check(1'b0, 1'b1, "pready timeout");
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // counts edges until vector load (sel 0) or wake request shows
    task automatic wait_sig(input int sel, input int lim, output int n);
        n = 0;
        while (((sel == 0) ? core_out.vector_load : core_out.wake_request)
               !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_sig

    task automatic pin(input logic v);
        @(posedge pclk);
        ext_irq_pin <= v;
        repeat (3) @(posedge pclk);
    endtask : pin

    task automatic pulse_ret();
        @(posedge pclk);
        ret_cmd <= 1'b1;
        @(posedge pclk);
        ret_cmd <= 1'b0;
    endtask : pulse_ret

    // watcher: oldest note against each answer
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            nt = notes.pop_front();
            check(pslverr, nt.err, "pslverr");
            if (nt.rd) check(prdata, {24'h0, nt.d}, "read data");
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h2dee));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_IRQ_CONTROL, 8'h00, RST_IRQ_CONTROL, 1'b0);
        apb(1'b0, IDX_PERIPH_FLAGS, 8'h00, RST_PERIPH, 1'b0);
        apb(1'b0, IDX_PERIPH_ENABLES, 8'h00, RST_PERIPH, 1'b0);
        apb(1'b0, IDX_OPTION, 8'h00, RST_OPTION, 1'b0);
        apb(1'b1, 10'h3ff, 8'h5a, 8'h00, 1'b1);
        apb(1'b0, 10'h3ff, 8'h00, 8'h00, 1'b1);
        // a random set of event flags, timer-zero and eeprom always among them, sets with all enables clear, and nothing vectors
        ev = 8'($urandom()) | 8'h81;
        @(posedge pclk);
        events <= ev;
        @(posedge pclk);
        events <= '0;
        apb(1'b0, IDX_PERIPH_FLAGS, 8'h00, {ev[0], ev[1], ev[2], ev[3],
            ev[4], ev[5], 1'b0, ev[6]}, 1'b0);
        apb(1'b0, IDX_IRQ_CONTROL, 8'h00, {5'h0, ev[7], 2'h0}, 1'b0);
        check(entries, 0, "entries");
        apb(1'b1, IDX_PERIPH_FLAGS, 8'h00, 8'h00, 1'b0);
        apb(1'b1, IDX_IRQ_CONTROL, 8'h00, 8'h00, 1'b0);
        apb(1'b1, IDX_PERIPH_ENABLES, 8'hff, 8'h00, 1'b0);
        apb(1'b0, IDX_PERIPH_ENABLES, 8'h00, 8'hfd, 1'b0);
        apb(1'b1, IDX_PERIPH_ENABLES, 8'h00, 8'h00, 1'b0);
        // rise, fall under rising select, then rise, fall under falling
        for (int k = 0; k < 4; k++) begin
            if (k == 2) apb(1'b1, IDX_OPTION, 8'h00, 8'h00, 1'b0);
            pin(k[0] == 1'b0);
            apb(1'b0, IDX_IRQ_CONTROL, 8'h00,
                {6'h0, k[0] == k[1], 1'b0}, 1'b0);
            apb(1'b1, IDX_IRQ_CONTROL, 8'h00, 8'h00, 1'b0);
        end
        // entry with enable set: latency, enable cleared, flag left set
        pin(1'b1);
        apb(1'b1, IDX_IRQ_CONTROL, 8'h90, 8'h00, 1'b0);
        @(posedge pclk);
        ext_irq_pin <= 1'b0;
        wait_sig(0, 40, lat);
        check(lat <= 16, 1'b1, "latency");
        apb(1'b0, IDX_IRQ_CONTROL, 8'h00, 8'h12, 1'b0);
        check(entries, 1, "entries");
        apb(1'b1, IDX_IRQ_CONTROL, 8'h10, 8'h00, 1'b0);
        pulse_ret();
        apb(1'b0, IDX_IRQ_CONTROL, 8'h00, 8'h90, 1'b0);
        // request held off while enable is clear, taken once it returns
        apb(1'b1, IDX_IRQ_CONTROL, 8'h10, 8'h00, 1'b0);
        pin(1'b1);
        pin(1'b0);
        wait_sig(0, 40, lat);
        check(lat, 40, "held entry");
        pulse_ret();
        wait_sig(0, 40, lat);
        check(lat < 40, 1'b1, "deferred entry");
        apb(1'b1, IDX_IRQ_CONTROL, 8'h90, 8'h00, 1'b0);
        @(posedge pclk);
        clr_cmd <= 1'b1;
        @(posedge pclk);
        clr_cmd <= 1'b0;
        apb(1'b0, IDX_IRQ_CONTROL, 8'h00, 8'h10, 1'b0);
        // sleep with a pending enabled request and enable clear
        pin(1'b1);
        pin(1'b0);
        @(posedge pclk);
        sleep_cmd <= 1'b1;
        @(posedge pclk);
        sleep_cmd <= 1'b0;
        wait_sig(1, 20, lat);
        check(lat < 20, 1'b1, "wake");
        check(entries, 2, "entries");
        // enabled port pin change sets its flag
        apb(1'b1, IDX_IRQ_CONTROL, 8'h00, 8'h00, 1'b0);
        apb(1'b1, IDX_PIN_CHANGE_ENABLE, 8'h01, 8'h00, 1'b0);
        @(posedge pclk);
        port_pins <= PORT_PINS'($urandom()) | 6'h01;
        apb(1'b0, IDX_IRQ_CONTROL, 8'h00, 8'h01, 1'b0);
        repeat (4) @(posedge pclk);
        results();
    end
endmodule : mcu_interrupt_logic_tb
